// [src/ctsr_regs.v]
// telemetry result and live status register bank of the charger
`timescale 1ns/10ps
`include "ctsr_defs.vh"
module ctsr_regs #(
    parameter DW = 16
) (
    input  wire          core_clk,          // 125 MHz clock
    input  wire          nrst,              // async reset, active low
    // analog comparator and detector levels, asynchronous to core_clk
    input  wire          charger_en,        // charger enabled level
    input  wire          freq_pin_open,     // pin impedance above 1.4 megohm
    input  wire          die_over_temp,     // die above shutdown temperature
    input  wire          input_over_volt,   // input above overvoltage limit
    input  wire          input_gt_bat,      // input above battery plus margin
    input  wire          input_gt_lockout,  // input above regulator lockout
    input  wire          intsup_gt_lockout, // internal supply above telemetry lockout
    input  wire          cell_count_bad,    // strapped cell count invalid
    // converter result stream, same clock domain
    input  wire          adc_valid,         // one-cycle result strobe
    input  wire [2:0]    adc_chan,          // result slot 0..7 (0x3a..0x41)
    input  wire [DW-1:0] adc_data,          // signed result word
    input  wire [DW-1:0] charge_setting,    // programmed charge current, battery current units
    // register read port
    input  wire          rd_req,            // one-cycle read request
    input  wire [7:0]    rd_cmd,            // command code
    output reg  [DW-1:0] rd_data_ff,        // read word
    output reg           rd_ack_ff,         // one-cycle answer strobe
    output reg           rd_err_ff,         // unmapped command flag
    output reg           resist_doubt_ff    // resistance reading doubtful
);
    // two-flop synchronisers for all analog levels
    reg [7:0] sync1_ff;
    reg [7:0] sync2_ff;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_ff <= 8'h00;
            sync2_ff <= 8'h00;
        end else begin
            sync1_ff <= {charger_en, cell_count_bad, freq_pin_open, die_over_temp,
                         input_over_volt, input_gt_bat, input_gt_lockout,
                         intsup_gt_lockout};
            sync2_ff <= sync1_ff;
        end
    end

    wire en_s = sync2_ff[7];

    // live status word: pure function of synced sources, never latched
    reg [`CTSR_STATUS_W-1:0] status_w;
    always @* begin
        status_w = {`CTSR_STATUS_W{1'b0}};
        status_w[`CTSR_BIT_ENCHG] = en_s;
        // telemetry off while disabled, so cell count error reads true
        status_w[`CTSR_BIT_CCERR] = sync2_ff[6] | ~en_s;
        status_w[`CTSR_BIT_NOFREQ] = sync2_ff[5] | ~en_s;
        status_w[`CTSR_BIT_TSD]   = sync2_ff[4];
        status_w[`CTSR_BIT_OVLO]  = sync2_ff[3];
        status_w[`CTSR_BIT_VGTB]  = sync2_ff[2];
        status_w[`CTSR_BIT_VGT42] = sync2_ff[1];
        status_w[`CTSR_BIT_INTOK] = sync2_ff[0];
    end

    // battery current: while disabled a non-negative sample is forced to -1,
    // since a disabled charger can only drain the battery
    wire        is_bat_cur  = (adc_chan == (`CTSR_CMD_BATI - `CTSR_CMD_BATV));
    wire        bat_cur_pos = ~adc_data[DW-1];
    wire [DW-1:0] wr_word = (is_bat_cur && !en_s && bat_cur_pos) ? `CTSR_NEG_ONE16
                                                            : adc_data;

    // doubtful flag: latest battery current below one tenth of setting
    reg [DW-1:0] tenth_ff;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tenth_ff        <= `CTSR_ZERO16;
            resist_doubt_ff <= 1'b0;
        end else begin
            tenth_ff <= charge_setting / `CTSR_DIV_TEN;
            if (adc_valid && is_bat_cur) begin
                resist_doubt_ff <= wr_word[DW-1] || (wr_word < tenth_ff);
            end
        end
    end

    // command decode: 0x39 status, 0x3a..0x41 results, others unmapped
    function [4:0] dec_cmd;
        input [7:0] cmd;
        reg   [7:0] off;
        begin
            off = cmd - `CTSR_CMD_BASE;
            if (cmd < `CTSR_CMD_BASE || off >= `CTSR_NUM_REGS) begin
                dec_cmd = 5'h10;
            end else begin
                dec_cmd = {1'b0, off[3:0]};
            end
        end
    endfunction

    wire [4:0] dec     = dec_cmd(rd_cmd);
    wire       is_stat = (dec == 5'h00);
    wire       miss    = dec[4];
    wire [2:0] slot    = dec[2:0] - 3'd1;

    // results 0x3a..0x41
    wire [DW-1:0] mem_q;
    ctsr_result_mem #(
        .DW    (DW),
        .DEPTH (8),
        .AW    (3)
    ) u_mem (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .wr_en      (adc_valid),
        .wr_addr    (adc_chan),
        .wr_data    (wr_word),
        .rd_addr    (slot),
        .rd_data_ff (mem_q)
    );

    // read pipeline: stage 1 registers the decode and memory read
    reg       p_req_ff;
    reg       p_stat_ff;
    reg       p_miss_ff;
    reg [8:0] p_status_ff;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            p_req_ff    <= 1'b0;
            p_stat_ff   <= 1'b0;
            p_miss_ff   <= 1'b0;
            p_status_ff <= 9'h000;
        end else begin
            p_req_ff    <= rd_req;
            p_stat_ff   <= is_stat;
            p_miss_ff   <= miss;
            p_status_ff <= status_w;
        end
    end

    // stage 2 answer; unmapped commands return zero with error flag
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_ff <= `CTSR_RESULT_RST;
            rd_ack_ff  <= 1'b0;
            rd_err_ff  <= 1'b0;
        end else begin
            rd_ack_ff <= p_req_ff;
            rd_err_ff <= p_req_ff & p_miss_ff;
            if (p_req_ff) begin
                if (p_miss_ff) begin
                    rd_data_ff <= `CTSR_ZERO16;
                end else if (p_stat_ff) begin
                    rd_data_ff <= {7'h00, p_status_ff};
                end else begin
                    rd_data_ff <= mem_q;
                end
            end
        end
    end
endmodule

// [src/ctsr_defs.vh]
// constants for the charger telemetry and status register bank
// Operation
// - bit 5 reports missing frequency resistor; forced true while charger disabled
// - missing resistor flag set when pin impedance exceeds about 1.4 megohm
// - bit 4 high while held in thermal shutdown, typically 150 C
// - bit 3 high while input overvoltage shutdown active, about 38.6 V
// - bit 2 high when input exceeds battery by charge margin, 150 mV
// - bit 1 high when input above regulator lockout, 4.2 V
// - bit 0 high when internal supply above telemetry lockout, 2.8 V
// - per-cell battery voltage signed 16-bit at code 0x3A
// - input voltage signed 16-bit at code 0x3B
// - output voltage signed 16-bit at code 0x3C
// - battery current at 0x3D; negative drain reading while charger disabled
// - input current signed 16-bit at code 0x3E
// - die temperature signed 16-bit at code 0x3F
// - thermistor pin voltage at 0x40; 21684 means open thermistor
// - per-cell battery resistance 16-bit at code 0x41
// - resistance-doubtful flag set when battery current below tenth of charge setting
// - live status flags read-only 9-bit register at code 0x39
`ifndef CTSR_DEFS_VH
`define CTSR_DEFS_VH
`define CTSR_CMD_STATUS   8'h39
`define CTSR_CMD_BATV     8'h3A
`define CTSR_CMD_INV      8'h3B
`define CTSR_CMD_OUTV     8'h3C
`define CTSR_CMD_BATI     8'h3D
`define CTSR_CMD_INI      8'h3E
`define CTSR_CMD_DIE      8'h3F
`define CTSR_CMD_NTC      8'h40
`define CTSR_CMD_CELLR    8'h41
`define CTSR_CMD_BASE     8'h39
`define CTSR_NUM_REGS     9
`define CTSR_IDX_W        4
`define CTSR_BIT_NOFREQ   5
`define CTSR_BIT_TSD      4
`define CTSR_BIT_OVLO     3
`define CTSR_BIT_VGTB     2
`define CTSR_BIT_VGT42    1
`define CTSR_BIT_INTOK    0
`define CTSR_BIT_CCERR    7
`define CTSR_BIT_ENCHG    8
`define CTSR_STATUS_W     9
`define CTSR_RESULT_RST   16'h0000
`define CTSR_NTC_OPEN     16'h54B4
`define CTSR_DIV_TEN      16'h000A
`define CTSR_ZERO16       16'h0000
`define CTSR_NEG_ONE16    16'hFFFF
`endif

// [src/ctsr_result_mem.v]
// small register memory holding the eight converter results
`timescale 1ns/10ps
module ctsr_result_mem #(
    parameter DW    = 16,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire          core_clk,  // system clock
    input  wire          nrst,      // async reset, active low
    input  wire          wr_en,     // write strobe
    input  wire [AW-1:0] wr_addr,   // write slot
    input  wire [DW-1:0] wr_data,   // write word
    input  wire [AW-1:0] rd_addr,   // read slot
    output reg  [DW-1:0] rd_data_ff // registered read word
);
    reg [DW-1:0] mem [0:DEPTH-1];
    integer i;

    // storage, cleared at reset so reads before first conversion give zero
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= {DW{1'b0}};
            end
        end else if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // registered read port; a same-cycle write is seen one cycle later
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rd_data_ff <= {DW{1'b0}};
        end else begin
            rd_data_ff <= mem[rd_addr];
        end
    end
endmodule

// [tb/ctsr_regs_monitor.sv]
// checker for the read port and the live status word
`timescale 1ns/10ps
module ctsr_regs_monitor #(parameter DW = 16) (
    input wire          core_clk,      // clock
    input wire          nrst,          // reset
    input wire          charger_en,    // enable
    input wire          freq_pin_open, // open pin
    input wire          die_over_temp, // overheat
    input wire          rd_req,        // request
    input wire [7:0]    rd_cmd,        // code
    input wire [DW-1:0] rd_data_ff,    // word
    input wire          rd_ack_ff,     // answer
    input wire          rd_err_ff      // unmapped
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // sources held steady for the two sync flops around a status read
    wire bad = rd_cmd < 8'h39 || rd_cmd > 8'h41;
    wire open_src = freq_pin_open || !charger_en;
    wire cold = !die_over_temp;
    sequence st; rd_req && rd_cmd == 8'h39; endsequence
    sequence open_hold; open_src[*5] ##0 st ##1 open_src; endsequence
    sequence hot; die_over_temp[*5] ##0 st ##1 die_over_temp; endsequence
    sequence cool; cold[*5] ##0 st ##1 cold; endsequence
    AST_ACK_LAT: assert property (rd_req |-> ##2 rd_ack_ff)
        else $error("late ack");
    AST_ACK_CAUSE: assert property (rd_ack_ff |-> $past(rd_req, 2))
        else $error("stray ack");
    AST_ERR_BAD: assert property (rd_req && bad |-> ##2 rd_err_ff && rd_data_ff == 0)
        else $error("unmapped code accepted");
    AST_ERR_OK: assert property (rd_req && !bad |-> ##2 !rd_err_ff)
        else $error("mapped code refused");
    AST_ST_HIGH: assert property (st |-> ##2 rd_data_ff[DW-1:9] == 0 && !rd_data_ff[6])
        else $error("status spare bits set");
    AST_NOFREQ: assert property (open_hold |-> ##1 rd_data_ff[5])
        else $error("open pin flag low");
    AST_TSD_SET: assert property (hot |-> ##1 rd_data_ff[4])
        else $error("shutdown flag low");
    AST_TSD_CLR: assert property (cool |-> ##1 !rd_data_ff[4])
        else $error("shutdown flag stuck");
endmodule
bind ctsr_regs ctsr_regs_monitor #(.DW(DW)) u_mon (.core_clk, .nrst, .charger_en,
    .freq_pin_open, .die_over_temp, .rd_req, .rd_cmd, .rd_data_ff, .rd_ack_ff, .rd_err_ff);

// [tb/ctsr_host_model.sv]
// host side model issuing single reads on the register port
`timescale 1ns/10ps
module ctsr_host_model (
    input wire        core_clk,   // clock
    output reg        rd_req,     // request
    output reg [7:0]  rd_cmd,     // code
    input wire [15:0] rd_data_ff, // word
    input wire        rd_ack_ff,  // answer
    input wire        rd_err_ff   // unmapped
);
    initial rd_req = 1'b0;
    initial rd_cmd = 8'h00;
    // one request edge, then wait a bounded time for the strobe
    task rd(input [7:0] c, output [15:0] d, output e, output to);
        integer n;
        begin
            @(negedge core_clk);
            rd_req = 1'b1;
            rd_cmd = c;
            @(negedge core_clk);
            rd_req = 1'b0;
            rd_cmd = ~c; // a stale code must not pass for the old one
            to = 1'b1;
            for (n = 0; n < 8 && to; n = n + 1) begin
                @(posedge core_clk);
                #1;
                if (rd_ack_ff === 1'b1) begin
                    to = 1'b0;
                    d = rd_data_ff;
                    e = rd_err_ff;
                end
            end
        end
    endtask
endmodule

// [tb/ctsr_regs_tb.sv]
// self-checking bench for the telemetry and status register bank
`timescale 1ns/10ps
module ctsr_regs_tb;
    reg         core_clk, nrst, adc_valid, e, to;
    reg  [7:0]  s;
    reg  [2:0]  adc_chan;
    reg  [15:0] adc_data, charge_setting, d;
    wire [15:0] rd_data_ff;
    wire [7:0]  rd_cmd;
    wire        rd_req, rd_ack_ff, rd_err_ff, resist_doubt_ff;
    wire        charger_en = s[7], cell_count_bad = s[6], freq_pin_open = s[5];
    wire        die_over_temp = s[4], input_over_volt = s[3], input_gt_bat = s[2];
    wire        input_gt_lockout = s[1], intsup_gt_lockout = s[0];
    integer     num_errors = 0, tests_run = 0, i;
    ctsr_regs dut (.core_clk, .nrst, .charger_en, .freq_pin_open, .die_over_temp,
        .input_over_volt, .input_gt_bat, .input_gt_lockout, .intsup_gt_lockout,
        .cell_count_bad, .adc_valid, .adc_chan, .adc_data, .charge_setting,
        .rd_req, .rd_cmd, .rd_data_ff, .rd_ack_ff, .rd_err_ff, .resist_doubt_ff);
    ctsr_host_model host (.core_clk, .rd_req, .rd_cmd, .rd_data_ff, .rd_ack_ff, .rd_err_ff);
    task summarize;
        begin
            $display("errors %0d checks %0d", num_errors, tests_run);
            if (num_errors == 0 && tests_run > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input [15:0] x, input [15:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== x) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t got %h want %h", $time, got, x);
            end
        end
    endtask
    task rd(input [7:0] c);
        begin
            host.rd(c, d, e, to);
            if (to) begin
                num_errors = num_errors + 1;
                $display("[ERR] %0t no answer", $time);
                summarize;
            end
        end
    endtask
    task set(input [7:0] v);
        begin
            @(negedge core_clk);
            s = v;
            repeat (5) @(negedge core_clk);
        end
    endtask
    task put(input [2:0] ch, input [15:0] v);
        begin
            @(negedge core_clk);
            adc_valid = 1'b1;
            adc_chan = ch;
            adc_data = v;
            @(negedge core_clk);
            adc_valid = 1'b0;
        end
    endtask
    // results read zero after reset; codes either side are refused
    task t_reset;
        for (i = 8'h38; i <= 8'h42; i = i + 1)
            if (i != 8'h39) begin
                rd(i[7:0]);
                chk(16'h0000, d);
                chk({15'h0, i == 8'h38 || i == 8'h42}, {15'h0, e});
            end
    endtask
    task t_results;
        begin
            for (i = 0; i < 8; i = i + 1)
                put(i[2:0], {~i[7:0], 8'hA5});
            for (i = 0; i < 8; i = i + 1) begin
                rd(8'h3A + i[7:0]);
                chk({~i[7:0], 8'hA5}, d);
            end
        end
    endtask
    task ib(input [15:0] v, input [15:0] x, input b);
        begin
            put(3'd3, v);
            rd(8'h3D);
            chk(x, d);
            chk({15'h0, b}, {15'h0, resist_doubt_ff});
        end
    endtask
    // drain while disabled, then the tenth of setting boundary
    task t_ibat;
        begin
            set(8'h00);
            ib(16'h0005, 16'hFFFF, 1'b1);
            set(8'h80);
            ib(16'h0009, 16'h0009, 1'b1);
            ib(16'h000A, 16'h000A, 1'b0);
        end
    endtask
    // each flag alone, then all clear to show nothing is latched
    task t_status;
        for (i = 0; i < 9; i = i + 1) begin
            set(i < 8 ? (8'h01 << i) ^ 8'h80 : 8'h80);
            rd(8'h39);
            chk({7'h0, s[7], s[6] | ~s[7], 1'b0, s[5] | ~s[7], s[4:0]}, d);
        end
    endtask
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    initial begin
        nrst = 1'b0;
        adc_valid = 1'b0;
        adc_chan = 3'h0;
        adc_data = 16'h0000;
        charge_setting = 16'h0064;
        s = 8'h80;
        repeat (10) @(negedge core_clk);
        nrst = 1'b1;
        t_reset;
        t_results;
        t_ibat;
        t_status;
        summarize;
    end
endmodule
